/* hw/dsp_map.svh */
// register map, bit positions, reset values and timing counts
`ifndef DSP_MAP_SVH
`define DSP_MAP_SVH
// ==========================================================
// register addresses on the sfr bus
`define DSP_A_SCON 8'h98
`define DSP_A_SBUF 8'h99
`define DSP_A_MODE 8'hc9
`define DSP_A_RLDL 8'hca
`define DSP_A_RLDH 8'hcb
`define DSP_A_CNTL 8'hcc
`define DSP_A_CNTH 8'hcd
// ==========================================================
// field positions
`define DSP_B_DIR 0
`define DSP_B_SPLIT 2
`define DSP_B_RI 0
`define DSP_B_TI 1
`define DSP_B_RB8 2
`define DSP_B_TB8 3
`define DSP_B_REN 4
// ==========================================================
// reset values
`define DSP_RST8 8'h00
`define DSP_LINK_RST 3'h1
// ==========================================================
// timing counts
`define DSP_MC_LAST 3'h5
`define DSP_M0_LAST 6'h05
`define DSP_M0_RISE 6'h03
`define DSP_OVS 16
`define DSP_CNT_MAX 16'hffff
`define DSP_M0_BITS 4'h8
`define DSP_M1_BITS 4'ha
`define DSP_M2_BITS 4'hb
`define DSP_M1_RXB 4'h9
`define DSP_M2_RXB 4'ha
`endif

/* hw/dsp_pkg.sv */
// types shared by the debug serial port and its link stage
package dsp_pkg;
    // ==========================================================
    // serial modes, in select-bit order
    typedef enum logic [1:0] {mode_shift, mode_10bit, mode_11fix,
        mode_11var} dsp_mode_t;
    // transmit and receive sequencers
    typedef enum logic [0:0] {tx_idle, tx_run} dsp_tx_st_t;
    typedef enum logic [1:0] {rx_idle, rx_start, rx_bits,
        rx_shift0} dsp_rx_st_t;
    // ==========================================================
    // all state of the cpu-side block
    typedef struct packed {
        logic [7:0] rld_lo;
        logic [7:0] rld_hi;
        logic [7:0] cnt_lo;
        logic [7:0] cnt_hi;
        logic dir;
        logic split;
        logic lo_pend;
        logic rd_lo_d;
        logic ovf;
        logic half_tk;
        logic [2:0] mc_div;
        logic [7:0] scon;
        logic [7:0] rx_buf;
        logic [7:0] rdata;
        dsp_tx_st_t tx_st;
        logic [10:0] tx_sh;
        logic [5:0] tx_tk;
        logic [3:0] tx_bit;
        logic tx_pin;
        logic d0_out;
        logic d0_oe;
        dsp_rx_st_t rx_st;
        logic [9:0] rx_sh;
        logic [5:0] rx_tk;
        logic [3:0] rx_bit;
        logic rx_s1;
        logic rx_s2;
        logic rx_prev;
    } dsp_state_t;
    // all state of the link stage
    typedef struct packed {
        logic [2:0] m1;
        logic [2:0] m2;
        logic r1;
        logic r2;
    } dsp_link_t;
endpackage : dsp_pkg

/* hw/dsp_link.sv */
// pin stage of the serial port, clocked by the link clock
`timescale 1ns/1ns
`include "dsp_map.svh"
module dsp_link
(
    // clock and reset
    input wire logic link_clk_i,
    input wire logic resetn_i,
    // levels from the cpu domain
    input wire logic tx_lvl_i,
    input wire logic dout_lvl_i,
    input wire logic doe_lvl_i,
    // pins
    input wire logic rx_i,
    output logic tx_o,
    output logic rx_o,
    output logic rx_oe_o,
    // received level toward the cpu domain
    output logic rx_lvl_o
);
    import dsp_pkg::*;
    dsp_link_t l_ff; // all state
    dsp_link_t nxt_l; // next state
    // ==========================================================
    // two flops per crossing level, both directions
    always_comb
    begin
        nxt_l = l_ff;
        nxt_l.m1 = {doe_lvl_i, dout_lvl_i, tx_lvl_i};
        nxt_l.m2 = l_ff.m1;
        nxt_l.r1 = rx_i;
        nxt_l.r2 = l_ff.r1;
    end
    // state register; tx idles high
    always_ff @(posedge link_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            l_ff.m1 <= `DSP_LINK_RST;
            l_ff.m2 <= `DSP_LINK_RST;
            l_ff.r1 <= 1'b1;
            l_ff.r2 <= 1'b1;
        end
        else
        begin
            l_ff <= nxt_l;
        end
    end
    // pins straight from the second stage
    assign tx_o = l_ff.m2[0];
    assign rx_o = l_ff.m2[1];
    assign rx_oe_o = l_ff.m2[2];
    assign rx_lvl_o = l_ff.r2;
endmodule : dsp_link

/* hw/dsp_top.sv */
// debug serial port with its 16-bit reload timer
// Behaviour
// - set split flag if high byte moves mid-read
// - clear split flag after next low read
// - direction bit outside baud generation: set counts up, clear down
// - low and high count bytes form one counter
// - reload copies reload bytes into count bytes
// - buffer address: write transmit, read receive
// - modes 1 to 3: receive shifter runs while buffer awaits read
// - unread buffer: newly completed byte is lost
// - two select bits pick one of four modes
// - mode 0: data on rx pin, clock on tx
// - mode 0: 8 bits lsb first, clk/6
// - mode 1: start, 8 data, stop
// - mode 1: stop bit stored as ninth bit
// - mode 1: rate from timer overflows
// - mode 2: start, 8 data, ninth, stop
// - mode 2: transmit ninth bit from control
// - mode 2: store ninth bit, ignore stop
// - mode 2: rate clk/16 or clk/32
// - mode 3: mode 2 frame, timer rate
// - any buffer write starts transmission
// - receive start conditions per mode
// - rx and tx each pick their overflow source
`timescale 1ns/1ns
`include "dsp_map.svh"
module dsp_top #(
    parameter int OVERSAMPLE = `DSP_OVS
)
(
    // clocks and reset
    input wire logic clk_i,
    input wire logic link_clk_i,
    input wire logic resetn_i,
    // sfr bus
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    // configuration and rate sources
    input wire logic tmr_run_i,
    input wire logic rx_rate_src_i,
    input wire logic tx_rate_src_i,
    input wire logic legacy_ovf_i,
    input wire logic half_rate_i,
    // serial pins
    input wire logic rx_i,
    output logic rx_o,
    output logic rx_oe_o,
    output logic tx_o
);
    import dsp_pkg::*;
    // ==========================================================
    // parameter check and derived counts
    if (OVERSAMPLE < 4 || OVERSAMPLE > 64)
    begin : g_bad_ovs
        $error("OVERSAMPLE must lie in 4..64");
    end
    localparam logic [5:0] TK_LAST = 6'(OVERSAMPLE - 1);
    localparam logic [5:0] TK_MID = 6'(OVERSAMPLE / 2 - 1);

    dsp_state_t s_ff; // all state
    dsp_state_t nxt_s; // next state
    logic rx_link; // rx level from link domain
    dsp_mode_t mode; // decoded mode
    logic [15:0] cnt; // current count
    logic [15:0] rld; // reload value
    logic [15:0] new_cnt; // count after hardware step
    logic baud; // baud generation active
    logic step; // timer step this cycle
    logic hw_ovf; // timer overflow this cycle
    logic hi_inc; // high byte moved by hardware
    logic set_split; // split flag set condition
    logic rd_lo; // read of low count byte
    logic tx_go; // buffer write
    logic tx_done; // last transmit bit ends
    logic tx_tick; // transmit rate tick
    logic rx_tick; // receive rate tick
    logic rx_done; // received byte complete
    logic [7:0] rx_data; // completed byte
    logic rx_b8; // completed ninth bit
    logic [9:0] nsh; // receive shifter with new bit
    logic [3:0] nb; // receive bits after start

    // ==========================================================
    // decoding helpers
    // frames with a ninth data bit
    function automatic logic nine_bit(input dsp_mode_t m);
        return m == mode_11fix || m == mode_11var;
    endfunction : nine_bit

    // oversample tick per channel
    function automatic logic rate_tick(input dsp_mode_t m,
        input logic src, input logic t2, input logic t1,
        input logic half, input logic ht);
        if (m == mode_11fix)
            return half ? ht : 1'b1;
        return src ? t2 : t1;
    endfunction : rate_tick

    // ==========================================================
    // next-state logic
    always_comb
    begin
        nxt_s = s_ff;
        mode = dsp_mode_t'(s_ff.scon[7:6]);
        cnt = {s_ff.cnt_hi, s_ff.cnt_lo};
        rld = {s_ff.rld_hi, s_ff.rld_lo};
        baud = rx_rate_src_i | tx_rate_src_i;
        // machine cycle prescaler, six clocks
        if (s_ff.mc_div == `DSP_MC_LAST)
            nxt_s.mc_div = 3'h0;
        else
            nxt_s.mc_div = s_ff.mc_div + 3'h1;
        step = tmr_run_i & (baud | (s_ff.mc_div == `DSP_MC_LAST));
        // one 16-bit counter across both bytes
        hw_ovf = 1'b0;
        new_cnt = cnt;
        if (step)
        begin
            if (baud || s_ff.dir)
            begin
                if (cnt == `DSP_CNT_MAX)
                begin
                    hw_ovf = 1'b1;
                    new_cnt = rld;
                end
                else
                    new_cnt = cnt + 16'h0001;
            end
            else if (cnt == rld)
            begin
                hw_ovf = 1'b1;
                new_cnt = `DSP_CNT_MAX;
            end
            else
                new_cnt = cnt - 16'h0001;
        end
        nxt_s.ovf = hw_ovf;
        {nxt_s.cnt_hi, nxt_s.cnt_lo} = new_cnt;
        hi_inc = (new_cnt[15:8] != s_ff.cnt_hi)
            && !(sfr_wr_i && sfr_addr_i == `DSP_A_CNTH);
        // split read tracking
        rd_lo = sfr_rd_i && sfr_addr_i == `DSP_A_CNTL;
        nxt_s.rd_lo_d = rd_lo;
        if (rd_lo)
            nxt_s.lo_pend = 1'b1;
        else if (sfr_rd_i && sfr_addr_i == `DSP_A_CNTH)
            nxt_s.lo_pend = 1'b0;
        set_split = s_ff.lo_pend & hi_inc;
        if (set_split)
            nxt_s.split = 1'b1;
        else if (s_ff.rd_lo_d)
            nxt_s.split = 1'b0;
        // firmware writes, which beat hardware count updates
        tx_go = 1'b0;
        if (sfr_wr_i)
        begin
            case (sfr_addr_i)
                `DSP_A_MODE: nxt_s.dir = sfr_wdata_i[`DSP_B_DIR];
                `DSP_A_RLDL: nxt_s.rld_lo = sfr_wdata_i;
                `DSP_A_RLDH: nxt_s.rld_hi = sfr_wdata_i;
                `DSP_A_CNTL: nxt_s.cnt_lo = sfr_wdata_i;
                `DSP_A_CNTH: nxt_s.cnt_hi = sfr_wdata_i;
                `DSP_A_SCON: nxt_s.scon = sfr_wdata_i;
                `DSP_A_SBUF: tx_go = 1'b1;
                default: ; // unmapped writes ignored
            endcase
        end
        // registered read data, held until next read
        if (sfr_rd_i)
        begin
            case (sfr_addr_i)
                `DSP_A_MODE: nxt_s.rdata = {5'h00, s_ff.split, 1'b0,
                    s_ff.dir};
                `DSP_A_RLDL: nxt_s.rdata = s_ff.rld_lo;
                `DSP_A_RLDH: nxt_s.rdata = s_ff.rld_hi;
                `DSP_A_CNTL: nxt_s.rdata = s_ff.cnt_lo;
                `DSP_A_CNTH: nxt_s.rdata = s_ff.cnt_hi;
                `DSP_A_SCON: nxt_s.rdata = s_ff.scon;
                `DSP_A_SBUF: nxt_s.rdata = s_ff.rx_buf;
                default: nxt_s.rdata = `DSP_RST8;
            endcase
        end
        // rate ticks
        nxt_s.half_tk = ~s_ff.half_tk;
        tx_tick = rate_tick(mode, tx_rate_src_i, s_ff.ovf,
            legacy_ovf_i, half_rate_i, s_ff.half_tk);
        rx_tick = rate_tick(mode, rx_rate_src_i, s_ff.ovf,
            legacy_ovf_i, half_rate_i, s_ff.half_tk);
        // transmit sequencer
        tx_done = 1'b0;
        case (s_ff.tx_st)
            tx_idle: ;
            tx_run:
            begin
                if (mode == mode_shift)
                begin
                    nxt_s.tx_tk = s_ff.tx_tk + 6'h01;
                    if (s_ff.tx_tk == `DSP_M0_LAST)
                    begin
                        nxt_s.tx_tk = 6'h00;
                        nxt_s.tx_sh = {1'b1, s_ff.tx_sh[10:1]};
                        nxt_s.tx_bit = s_ff.tx_bit - 4'h1;
                        tx_done = s_ff.tx_bit == 4'h1;
                    end
                end
                else if (tx_tick)
                begin
                    nxt_s.tx_tk = s_ff.tx_tk + 6'h01;
                    if (s_ff.tx_tk == TK_LAST)
                    begin
                        nxt_s.tx_tk = 6'h00;
                        nxt_s.tx_sh = {1'b1, s_ff.tx_sh[10:1]};
                        nxt_s.tx_bit = s_ff.tx_bit - 4'h1;
                        tx_done = s_ff.tx_bit == 4'h1;
                    end
                end
                if (tx_done)
                    nxt_s.tx_st = tx_idle;
            end
            default: nxt_s.tx_st = tx_idle;
        endcase
        // a buffer write loads a fresh frame, lsb first
        if (tx_go)
        begin
            nxt_s.tx_st = tx_run;
            nxt_s.tx_tk = 6'h00;
            if (mode == mode_shift)
            begin
                nxt_s.tx_sh = {3'h7, sfr_wdata_i};
                nxt_s.tx_bit = `DSP_M0_BITS;
            end
            else if (nine_bit(mode))
            begin
                nxt_s.tx_sh = {1'b1, s_ff.scon[`DSP_B_TB8],
                    sfr_wdata_i, 1'b0};
                nxt_s.tx_bit = `DSP_M2_BITS;
            end
            else
            begin
                nxt_s.tx_sh = {2'h3, sfr_wdata_i, 1'b0};
                nxt_s.tx_bit = `DSP_M1_BITS;
            end
        end
        // receive sequencer
        nxt_s.rx_s1 = rx_link;
        nxt_s.rx_s2 = s_ff.rx_s1;
        nxt_s.rx_prev = s_ff.rx_s2;
        nsh = {s_ff.rx_s2, s_ff.rx_sh[9:1]};
        nb = (mode == mode_10bit) ? `DSP_M1_RXB : `DSP_M2_RXB;
        rx_done = 1'b0;
        rx_data = nsh[7:0];
        rx_b8 = nsh[8];
        case (s_ff.rx_st)
            rx_idle:
            begin
                nxt_s.rx_tk = 6'h00;
                nxt_s.rx_bit = 4'h0;
                if (s_ff.scon[`DSP_B_REN])
                begin
                    if (mode == mode_shift)
                    begin
                        if (!s_ff.scon[`DSP_B_RI]
                            && s_ff.tx_st == tx_idle)
                            nxt_s.rx_st = rx_shift0;
                    end
                    else if (s_ff.rx_prev && !s_ff.rx_s2)
                        nxt_s.rx_st = rx_start;
                end
            end
            rx_start:
            begin
                if (rx_tick)
                begin
                    nxt_s.rx_tk = s_ff.rx_tk + 6'h01;
                    if (s_ff.rx_tk == TK_MID)
                    begin
                        nxt_s.rx_tk = 6'h00;
                        // false start falls back to idle
                        nxt_s.rx_st = s_ff.rx_s2 ? rx_idle : rx_bits;
                    end
                end
            end
            rx_bits:
            begin
                if (rx_tick)
                begin
                    nxt_s.rx_tk = s_ff.rx_tk + 6'h01;
                    if (s_ff.rx_tk == TK_LAST)
                    begin
                        nxt_s.rx_tk = 6'h00;
                        nxt_s.rx_sh = nsh;
                        nxt_s.rx_bit = s_ff.rx_bit + 4'h1;
                        if (s_ff.rx_bit == nb - 4'h1)
                        begin
                            rx_done = 1'b1;
                            nxt_s.rx_st = rx_idle;
                            if (mode == mode_10bit)
                            begin
                                rx_data = nsh[8:1];
                                rx_b8 = nsh[9];
                            end
                        end
                    end
                end
            end
            rx_shift0:
            begin
                nxt_s.rx_tk = s_ff.rx_tk + 6'h01;
                if (s_ff.rx_tk == `DSP_M0_RISE)
                    nxt_s.rx_sh = nsh;
                if (s_ff.rx_tk == `DSP_M0_LAST)
                begin
                    nxt_s.rx_tk = 6'h00;
                    nxt_s.rx_bit = s_ff.rx_bit + 4'h1;
                    if (s_ff.rx_bit == `DSP_M0_BITS - 4'h1)
                    begin
                        rx_done = 1'b1;
                        nxt_s.rx_st = rx_idle;
                        rx_data = s_ff.rx_sh[9:2];
                        rx_b8 = s_ff.scon[`DSP_B_RB8];
                    end
                end
            end
            default: nxt_s.rx_st = rx_idle;
        endcase
        // completion; hardware sets win over firmware clears
        if (tx_done)
            nxt_s.scon[`DSP_B_TI] = 1'b1;
        if (rx_done && !s_ff.scon[`DSP_B_RI])
        begin
            nxt_s.rx_buf = rx_data;
            nxt_s.scon[`DSP_B_RB8] = rx_b8;
            nxt_s.scon[`DSP_B_RI] = 1'b1;
        end
        // pin levels: mode 0 clock on tx, data on rx
        nxt_s.d0_oe = s_ff.tx_st == tx_run && mode == mode_shift;
        nxt_s.d0_out = s_ff.tx_sh[0];
        if (nxt_s.d0_oe)
            nxt_s.tx_pin = s_ff.tx_tk >= `DSP_M0_RISE;
        else if (s_ff.rx_st == rx_shift0)
            nxt_s.tx_pin = s_ff.rx_tk >= `DSP_M0_RISE;
        else if (s_ff.tx_st == tx_run)
            nxt_s.tx_pin = s_ff.tx_sh[0];
        else
            nxt_s.tx_pin = 1'b1;
    end

    // state register
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            s_ff <= '0;
            s_ff.tx_pin <= 1'b1;
            s_ff.rx_s1 <= 1'b1;
            s_ff.rx_s2 <= 1'b1;
            s_ff.rx_prev <= 1'b1;
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    assign sfr_rdata_o = s_ff.rdata;

    // ==========================================================
    // link-clock pin stage
    dsp_link u_link (
        .link_clk_i(link_clk_i),
        .resetn_i(resetn_i),
        .tx_lvl_i(s_ff.tx_pin),
        .dout_lvl_i(s_ff.d0_out),
        .doe_lvl_i(s_ff.d0_oe),
        .rx_i(rx_i),
        .tx_o(tx_o),
        .rx_o(rx_o),
        .rx_oe_o(rx_oe_o),
        .rx_lvl_o(rx_link)
    );

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    sequence s_m0_go;
        tx_go && mode == mode_shift && s_ff.tx_st == tx_idle;
    endsequence
    sequence s_m0_frame;
        (s_ff.tx_st == tx_run) ##47 (s_ff.tx_st == tx_run)
            ##1 (s_ff.tx_st == tx_idle && s_ff.scon[`DSP_B_TI]);
    endsequence

    chk_split_set: assert property (
        set_split |=> s_ff.split)
        else $error("split flag not set");
    chk_split_clr: assert property (
        rd_lo && !set_split ##1 !set_split |=> !s_ff.split)
        else $error("split flag not cleared");
    chk_count_up: assert property (
        step && s_ff.dir && !hw_ovf && !sfr_wr_i
        |=> {s_ff.cnt_hi, s_ff.cnt_lo} == $past(cnt) + 16'h0001)
        else $error("up count wrong");
    chk_reload_copy: assert property (
        hw_ovf && (baud || s_ff.dir) && !sfr_wr_i
        |=> {s_ff.cnt_hi, s_ff.cnt_lo} == $past(rld))
        else $error("reload not copied");
    chk_tx_start: assert property (
        tx_go |=> s_ff.tx_st == tx_run && s_ff.tx_tk == 6'h00)
        else $error("buffer write did not start");
    chk_tx_ninth: assert property (
        tx_go && nine_bit(mode)
        |=> s_ff.tx_sh[9] == $past(s_ff.scon[`DSP_B_TB8]))
        else $error("ninth bit not loaded");
    chk_rx_lost: assert property (
        rx_done && s_ff.scon[`DSP_B_RI]
        |=> s_ff.rx_buf == $past(s_ff.rx_buf))
        else $error("unread byte overwritten");
    chk_rx_ninth: assert property (
        rx_done && nine_bit(mode) && !s_ff.scon[`DSP_B_RI]
        |=> s_ff.scon[`DSP_B_RB8] == $past(nsh[8])
            && s_ff.scon[`DSP_B_RI])
        else $error("ninth bit not stored");
    chk_m0_rate: assert property (
        s_m0_go |=> s_m0_frame)
        else $error("mode 0 frame length wrong");
endmodule : dsp_top

/* tb/dsp_peer.sv */
// far-end serial model: sends frames and catches frames
`timescale 1ns/1ns
module dsp_peer
(
    // bit timing clock
    input wire logic clk_i,
    // port tx pin and the merged rx wire
    input wire logic txd_i,
    input wire logic rxw_i,
    // line into the port, idles at the stop level
    output logic line_o
);
    // ==========================================================
    // frame sender, lsb first, then idle high a while
    initial line_o = 1'b1;
    task automatic send(input logic [10:0] f, input int n,
        input int per);
        for (int i = 0; i < n; i++)
        begin
            line_o <= f[i];
            repeat (per) @(posedge clk_i);
        end
        line_o <= 1'b1;
        repeat (8) @(posedge clk_i);
    endtask : send
    // ==========================================================
    // frame catcher; per of zero means shift clock mode
    task automatic grab(output logic [10:0] f, input int n,
        input int per);
        f = 11'h7ff;
        if (per == 0)
        begin
            for (int i = 0; i < n; i++)
            begin
                @(posedge txd_i);
                f[i] = rxw_i;
            end
        end
        else
        begin
            @(negedge txd_i);
            repeat (per / 2) @(posedge clk_i);
            for (int i = 0; i < n; i++)
            begin
                f[i] = txd_i;
                repeat (per) @(posedge clk_i);
            end
        end
    endtask : grab
endmodule : dsp_peer

/* tb/tb_dsp_top.sv */
// testbench of the debug serial port and reload timer
`timescale 1ns/1ns
module tb_dsp_top;
    import dsp_pkg::*;
    // ==========================================================
    // stimulus, observed pins and score
    localparam int OVS = 16;
    logic clk = 1'b0, link_clk = 1'b0, resetn = 1'b0;
    logic wr = 1'b0, rd = 1'b0, run = 1'b0, legacy = 1'b0;
    logic rx_src = 1'b0, tx_src = 1'b0, half = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v;
    logic peer_line, rx_drv, rx_oe, tx_line;
    logic [10:0] f;
    int miscompares = 0, comparisons = 0, cycles = 0;
    // rx wire: port drives only while its enable is high
    wire rx_wire = rx_oe ? rx_drv : peer_line;
    initial forever #20 clk = ~clk;
    initial #5 forever #6 link_clk = ~link_clk;
    // other timer overflow: a pulse every second cycle
    always @(posedge clk)
    begin
        legacy <= ~legacy;
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            miscompares++;
            close_out();
        end
    end
    dsp_top #(.OVERSAMPLE(OVS)) u_dsp_top
    (
        .clk_i(clk), .link_clk_i(link_clk), .resetn_i(resetn),
        .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_rd_i(rd),
        .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .tmr_run_i(run),
        .rx_rate_src_i(rx_src), .tx_rate_src_i(tx_src),
        .legacy_ovf_i(legacy), .half_rate_i(half), .rx_i(rx_wire),
        .rx_o(rx_drv), .rx_oe_o(rx_oe), .tx_o(tx_line)
    );
    dsp_peer u_dsp_peer
    (
        .clk_i(clk), .txd_i(tx_line), .rxw_i(rx_wire),
        .line_o(peer_line)
    );
    // ==========================================================
    // bus cycles and comparison
    task automatic chk(input logic [10:0] s, input logic [10:0] e);
        comparisons++;
        if (s !== e)
        begin
            miscompares++;
            $display("FAIL at %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : bus_wr
    task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask : bus_rd
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        bus_rd(a, d);
        chk({3'h0, d}, {3'h0, e});
    endtask : rdc
    task automatic close_out();
        $display("miscompares %0d comparisons %0d", miscompares,
            comparisons);
        if (miscompares == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out
    // ==========================================================
    // main sequence
    initial
    begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        for (int a = 8'hc9; a <= 8'hcd; a++)
            rdc(a[7:0], 8'h00);
        rdc(8'h50, 8'h00);
        bus_wr(8'hc9, 8'hff);
        rdc(8'hc9, 8'h01);
        bus_wr(8'hca, 8'h5a);
        bus_wr(8'hcb, 8'ha5);
        // baud mode: count up through ffff into the reload value
        bus_wr(8'hcc, 8'hf0);
        bus_wr(8'hcd, 8'hff);
        tx_src <= 1'b1;
        run <= 1'b1;
        repeat (40) @(posedge clk);
        run <= 1'b0;
        rdc(8'hcd, 8'ha5);
        bus_rd(8'hcc, v);
        chk({10'h0, v > 8'h5a && v < 8'h80}, 11'h001);
        // carry into the high byte between two byte reads
        bus_wr(8'hcc, 8'hf8);
        bus_wr(8'hcd, 8'h00);
        run <= 1'b1;
        bus_rd(8'hcc, v);
        repeat (20) @(posedge clk);
        rdc(8'hcd, 8'h01);
        run <= 1'b0;
        rdc(8'hc9, 8'h05);
        bus_rd(8'hcc, v);
        repeat (2) @(posedge clk);
        rdc(8'hc9, 8'h01);
        // direction clear: count down toward the reload value
        bus_wr(8'hc9, 8'h00);
        bus_wr(8'hca, 8'h10);
        bus_wr(8'hcb, 8'h00);
        bus_wr(8'hcc, 8'h20);
        tx_src <= 1'b0;
        run <= 1'b1;
        repeat (60) @(posedge clk);
        run <= 1'b0;
        bus_rd(8'hcc, v);
        chk({10'h0, v > 8'h10 && v < 8'h20}, 11'h001);
        // mode 2 transmit with ninth bit set, then receive
        bus_wr(8'h98, 8'h88);
        bus_wr(8'h99, 8'h35);
        u_dsp_peer.grab(f, 11, OVS);
        chk(f, {2'b11, 8'h35, 1'b0});
        rdc(8'h98, 8'h8a);
        bus_wr(8'h98, 8'h98);
        u_dsp_peer.send({2'b00, 8'hc3, 1'b0}, 11, OVS);
        rdc(8'h98, 8'h99);
        rdc(8'h99, 8'hc3);
        u_dsp_peer.send({2'b11, 8'h3c, 1'b0}, 11, OVS);
        rdc(8'h99, 8'hc3);
        bus_wr(8'h98, 8'h98);
        u_dsp_peer.send({2'b11, 8'h3c, 1'b0}, 11, OVS);
        rdc(8'h98, 8'h9d);
        rdc(8'h99, 8'h3c);
        // mode 1 paced by the other timer's overflow pulses
        bus_wr(8'h98, 8'h50);
        u_dsp_peer.send({2'b11, 8'ha6, 1'b0}, 10, 2 * OVS);
        rdc(8'h98, 8'h55);
        rdc(8'h99, 8'ha6);
        bus_wr(8'h99, 8'h5e);
        u_dsp_peer.grab(f, 10, 2 * OVS);
        chk(f, {2'b11, 8'h5e, 1'b0});
        // mode 0: shift clock on tx, data on the rx wire
        bus_wr(8'h98, 8'h00);
        bus_wr(8'h99, 8'h96);
        u_dsp_peer.grab(f, 8, 0);
        repeat (16) @(posedge clk);
        chk(f, {3'h7, 8'h96});
        rdc(8'h98, 8'h02);
        // mode 3 transmit paced by the other timer's overflow pulses
        bus_wr(8'h98, 8'hc8);
        bus_wr(8'h99, 8'ha3);
        u_dsp_peer.grab(f, 11, 2 * OVS);
        chk(f, {2'b11, 8'ha3, 1'b0});
        // mode 2 transmit at the slower fixed fraction
        half <= 1'b1;
        bus_wr(8'h98, 8'h88);
        bus_wr(8'h99, 8'h3a);
        u_dsp_peer.grab(f, 11, 2 * OVS);
        chk(f, {2'b11, 8'h3a, 1'b0});
        close_out();
    end
endmodule : tb_dsp_top
